/* File: imd_pkg.sv */
// Constants, types and register map of the diagnostic and rate block
// Assumes a 20 MHz system clock and a 16-bit framed serial link
package imd_pkg;

    // *****************************************************************
    // Link framing
    // *****************************************************************
    localparam int unsigned FRAME_BITS  = 16;
    localparam int unsigned FRAME_CNT_W = 4;
    localparam int unsigned ADDR_W      = 7;

    // *****************************************************************
    // Register byte addresses
    // *****************************************************************
    localparam logic [6:0] ADDR_DIAG     = 7'h02;
    localparam logic [6:0] ADDR_X_FRAC   = 7'h04;
    localparam logic [6:0] ADDR_X_INT    = 7'h06;
    localparam logic [6:0] ADDR_Y_FRAC   = 7'h08;
    localparam logic [6:0] ADDR_Y_INT    = 7'h0A;
    localparam logic [6:0] ADDR_Z_FRAC   = 7'h0C;
    localparam logic [6:0] ADDR_Z_INT    = 7'h0E;
    localparam logic [6:0] ADDR_MISC_IO  = 7'h60;
    localparam logic [6:0] ADDR_GLOBAL_COMMAND = 7'h68;

    // *****************************************************************
    // Field positions and reset values
    // *****************************************************************
    localparam int unsigned FLAG_CLOCK   = 7;
    localparam int unsigned FLAG_CRC     = 6;
    localparam int unsigned FLAG_SENSOR  = 5;
    localparam int unsigned FLAG_STANDBY = 4;
    localparam int unsigned FLAG_FRAMING = 3;
    localparam int unsigned FLAG_UPDATE  = 2;
    localparam int unsigned FLAG_OVERRUN = 1;
    localparam logic [7:0]  FLAG_USED    = 8'hFE;
    localparam logic [7:0]  FLAGS_RST    = 8'h00;
    localparam logic [15:0] MISC_IO_RST  = 16'h00C1;
    localparam int unsigned SYNC_MODE_LO = 2;
    localparam logic [1:0]  SYNC_SCALED  = 2'h2;
    localparam int unsigned CMD_SELFTEST = 2;
    localparam int unsigned CMD_UPDATE   = 3;
    localparam int unsigned CMD_CRCTEST  = 4;
    localparam int unsigned CMD_RESET    = 7;

    // *****************************************************************
    // Rate format limits
    // *****************************************************************
    localparam logic [31:0] RATE_POS_FS = 32'h4E200000;
    localparam logic [31:0] RATE_NEG_FS = 32'hB1E00000;

    // *****************************************************************
    // Timing
    // *****************************************************************
    localparam longint unsigned CLK_HZ     = 20000000;
    localparam longint unsigned STANDBY_MS = 250;
    localparam int unsigned STANDBY_CYCLES =
        int'((STANDBY_MS * CLK_HZ) / 1000);

    // *****************************************************************
    // Synchroniser lanes
    // *****************************************************************
    localparam int unsigned SYNC_W    = 4;
    localparam int unsigned SY_CS     = 0;
    localparam int unsigned SY_TGL    = 1;
    localparam int unsigned SY_PART   = 2;
    localparam int unsigned SY_SUPPLY = 3;
    localparam logic [3:0]  SYNC_RST  = 4'h1;

    // *****************************************************************
    // Types
    // *****************************************************************
    typedef logic [31:0] imd_rate_t;
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_STANDBY,
        PWR_WAIT
    } imd_pwr_t;

endpackage

/* File: imd_link_if.sv */
// Link carrier between the serial shifter and the register core
// Assumes words are quasi-static while the other side samples them
`timescale 1ns/1ps
interface imd_link_if;
    logic [15:0] rx_word;
    logic        word_tgl;
    logic        partial;
    logic [15:0] tx_word;

    modport shifter (
        output rx_word,
        output word_tgl,
        output partial,
        input  tx_word
    );
    modport core (
        input  rx_word,
        input  word_tgl,
        input  partial,
        output tx_word
    );
endinterface

/* File: imd_spi_shifter.sv */
// Serial shifter clocked by the link clock, mode 3, MSB first
// Assumes select high between frames and reset applied while idle
`timescale 1ns/1ps
module imd_spi_shifter (
    input  wire logic   sclk_i,
    input  wire logic   cs_n_i,
    input  wire logic   rst_i,
    input  wire logic   din_i,
    output logic        dout_o,
    output logic        dout_oe_n_o,
    imd_link_if.shifter link
);
    import imd_pkg::*;

    typedef struct packed {
        logic [FRAME_CNT_W-1:0] cnt;
        logic [FRAME_BITS-2:0]  shift;
        logic [FRAME_BITS-1:0]  rx;
        logic                   tgl;
        logic                   partial;
    } imd_shift_t;

    imd_shift_t             st_reg;
    imd_shift_t             st_next;
    logic                   fresh_reg;
    logic [FRAME_CNT_W-1:0] bit_idx;

    // *****************************************************************
    // Frame start marker
    // *****************************************************************
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
        end
    end

    assign bit_idx = fresh_reg ? '0 : st_reg.cnt;

    // *****************************************************************
    // Shift and word capture
    // *****************************************************************
    always_comb begin
        st_next       = st_reg;
        st_next.cnt   = bit_idx + 1'b1;
        st_next.shift = {st_reg.shift[FRAME_BITS-3:0], din_i};
        st_next.partial = (st_next.cnt != '0);
        if (bit_idx == FRAME_CNT_W'(FRAME_BITS - 1)) begin
            st_next.rx  = {st_reg.shift, din_i};
            st_next.tgl = ~st_reg.tgl;
        end
    end

    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // *****************************************************************
    // Outputs
    // *****************************************************************
    assign link.rx_word  = st_reg.rx;
    assign link.word_tgl = st_reg.tgl;
    assign link.partial  = st_reg.partial;
    assign dout_o        = link.tx_word[~bit_idx];
    assign dout_oe_n_o   = cs_n_i;

endmodule

/* File: imd_diag_rate.sv */
// Diagnostic flag register and angular rate outputs behind a serial link
// Assumes one 16-bit word per select, with a short idle gap between words
`timescale 1ns/1ps
module imd_diag_rate #(
    parameter int unsigned STANDBY_WAIT = imd_pkg::STANDBY_CYCLES
) (
    // System clock and reset
    input  wire logic              CLK_SYS_I,
    input  wire logic              RST_I,
    // Serial link pins
    input  wire logic              SCLK_I,
    input  wire logic              CS_N_I,
    input  wire logic              DIN_I,
    output logic                   DOUT_O,
    output logic                   DOUT_OE_N_O,
    // Sensor data
    input  wire imd_pkg::imd_rate_t RATE_X_I,
    input  wire imd_pkg::imd_rate_t RATE_Y_I,
    input  wire imd_pkg::imd_rate_t RATE_Z_I,
    input  wire logic              RATE_VALID_I,
    // Condition reports
    input  wire logic              CLK_UNLOCK_I,
    input  wire logic              CRC_TEST_DONE_I,
    input  wire logic              CRC_MISMATCH_I,
    input  wire logic              SELF_TEST_DONE_I,
    input  wire logic              SENSOR_FAIL_I,
    input  wire logic              FLASH_UPDATE_DONE_I,
    input  wire logic              FLASH_UPDATE_OK_I,
    input  wire logic              OVERRUN_I,
    input  wire logic              SUPPLY_LOW_I,
    // Commands and mode
    output logic [1:0]             SYNC_MODE_O,
    output logic                   CRC_TEST_START_O,
    output logic                   SELF_TEST_START_O,
    output logic                   FLASH_UPDATE_START_O,
    output logic                   SOFT_RESET_O,
    output logic                   STANDBY_O,
    output logic                   REINIT_O
);
    import imd_pkg::*;

    // *****************************************************************
    // State
    // *****************************************************************
    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] filt;
        logic              tgl_seen;
        logic              cs_seen;
        logic [7:0]        flags;
        logic [15:0]       misc;
        logic [15:0]       tx;
        logic [2:0][31:0]  rate;
        logic [2:0][15:0]  snap;
        logic [2:0]        snap_vld;
        imd_pwr_t          pwr;
        logic [31:0]       wait_cnt;
        logic              cmd_crc;
        logic              cmd_self;
        logic              cmd_update;
        logic              cmd_reset;
        logic              reinit;
    } imd_core_t;

    imd_core_t          st_reg;
    imd_core_t          st_next;
    logic [SYNC_W-1:0]  pins;
    logic               word_evt;
    logic               frame_end;
    logic               is_read;
    logic [ADDR_W-1:0]  addr;
    logic [7:0]         wdata;
    logic [7:0]         flag_set;
    logic [7:0]         flag_clr;

    imd_link_if link ();

    // *****************************************************************
    // Link side shifter
    // *****************************************************************
    imd_spi_shifter u_shifter (
        .sclk_i      (SCLK_I),
        .cs_n_i      (CS_N_I),
        .rst_i       (RST_I),
        .din_i       (DIN_I),
        .dout_o      (DOUT_O),
        .dout_oe_n_o (DOUT_OE_N_O),
        .link        (link.shifter)
    );

    // *****************************************************************
    // Decoding helpers
    // *****************************************************************
    function automatic logic same_word(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] base
    );
        same_word = (a[ADDR_W-1:1] == base[ADDR_W-1:1]);
    endfunction

    function automatic logic [1:0] axis_of(input logic [ADDR_W-1:0] a);
        axis_of = 2'h3;
        if (same_word(a, ADDR_X_FRAC) || same_word(a, ADDR_X_INT)) begin
            axis_of = 2'h0;
        end else if (same_word(a, ADDR_Y_FRAC)
                     || same_word(a, ADDR_Y_INT)) begin
            axis_of = 2'h1;
        end else if (same_word(a, ADDR_Z_FRAC)
                     || same_word(a, ADDR_Z_INT)) begin
            axis_of = 2'h2;
        end
    endfunction

    function automatic logic is_frac(input logic [ADDR_W-1:0] a);
        is_frac = same_word(a, ADDR_X_FRAC) || same_word(a, ADDR_Y_FRAC)
                  || same_word(a, ADDR_Z_FRAC);
    endfunction

    function automatic logic [31:0] clamp_rate(input logic [31:0] r);
        clamp_rate = r;
        if ($signed(r) > $signed(RATE_POS_FS)) begin
            clamp_rate = RATE_POS_FS;
        end else if ($signed(r) < $signed(RATE_NEG_FS)) begin
            clamp_rate = RATE_NEG_FS;
        end
    endfunction

    // *****************************************************************
    // Frame decode
    // *****************************************************************
    assign pins      = {SUPPLY_LOW_I, link.partial, link.word_tgl, CS_N_I};
    assign word_evt  = (st_reg.filt[SY_TGL] != st_reg.tgl_seen);
    assign frame_end = st_reg.filt[SY_CS] && !st_reg.cs_seen;
    assign is_read   = !link.rx_word[15];
    assign addr      = link.rx_word[14:8];
    assign wdata     = link.rx_word[7:0];

    // *****************************************************************
    // Flag events
    // *****************************************************************
    always_comb begin
        flag_set = '0;
        flag_set[FLAG_CLOCK] = CLK_UNLOCK_I
            && (st_reg.misc[SYNC_MODE_LO+:2] == SYNC_SCALED);
        flag_set[FLAG_CRC] = CRC_TEST_DONE_I && CRC_MISMATCH_I;
        flag_set[FLAG_SENSOR] = SELF_TEST_DONE_I
            && SENSOR_FAIL_I;
        flag_set[FLAG_STANDBY] = st_reg.filt[SY_SUPPLY];
        flag_set[FLAG_FRAMING] = frame_end
            && st_reg.filt[SY_PART];
        flag_set[FLAG_UPDATE] = FLASH_UPDATE_DONE_I
            && !FLASH_UPDATE_OK_I;
        flag_set[FLAG_OVERRUN] = OVERRUN_I;
        flag_set = flag_set & FLAG_USED;
        flag_clr = '0;
        if (word_evt && is_read && same_word(addr, ADDR_DIAG)) begin
            flag_clr = FLAG_USED;
        end
    end

    // *****************************************************************
    // Next state
    // *****************************************************************
    always_comb begin
        logic [1:0] ax;
        ax = axis_of(addr);
        st_next = st_reg;
        st_next.cmd_crc    = 1'b0;
        st_next.cmd_self   = 1'b0;
        st_next.cmd_update = 1'b0;
        st_next.cmd_reset  = 1'b0;
        st_next.reinit     = 1'b0;

        // Pin and cross-clock synchronisers
        st_next.s1 = pins;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < SYNC_W; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.filt[i] = st_reg.s3[i];
            end
        end
        st_next.tgl_seen = st_reg.filt[SY_TGL];
        st_next.cs_seen  = st_reg.filt[SY_CS];

        // Sticky flags, a new event beats the clear
        st_next.flags = (st_reg.flags & ~flag_clr) | flag_set;

        // Supply watch
        unique case (st_reg.pwr)
            PWR_RUN: begin
                if (st_reg.filt[SY_SUPPLY]) begin
                    st_next.pwr = PWR_STANDBY;
                end
            end
            PWR_STANDBY: begin
                st_next.wait_cnt = '0;
                if (!st_reg.filt[SY_SUPPLY]) begin
                    st_next.pwr = PWR_WAIT;
                end
            end
            PWR_WAIT: begin
                st_next.wait_cnt = st_reg.wait_cnt + 32'h1;
                if (st_reg.filt[SY_SUPPLY]) begin
                    st_next.pwr = PWR_STANDBY;
                end else if (st_reg.wait_cnt >= STANDBY_WAIT - 1) begin
                    st_next.pwr    = PWR_RUN;
                    st_next.reinit = 1'b1;
                end
            end
            default: begin
                st_next.pwr = PWR_STANDBY;
            end
        endcase

        // Rate capture, halted outside run
        if (RATE_VALID_I && st_reg.pwr == PWR_RUN) begin
            st_next.rate[0] = clamp_rate(RATE_X_I);
            st_next.rate[1] = clamp_rate(RATE_Y_I);
            st_next.rate[2] = clamp_rate(RATE_Z_I);
        end

        // Register access
        if (word_evt && is_read) begin
            st_next.tx = 16'h0000;
            if (same_word(addr, ADDR_DIAG)) begin
                st_next.tx = {8'h00, st_reg.flags & FLAG_USED};
            end else if (same_word(addr, ADDR_MISC_IO)) begin
                st_next.tx = st_reg.misc;
            end else if (ax != 2'h3 && is_frac(addr)) begin
                st_next.tx = st_reg.rate[ax][15:0];
                st_next.snap[ax] = st_reg.rate[ax][31:16];
                st_next.snap_vld[ax] = 1'b1;
            end else if (ax != 2'h3) begin
                st_next.snap_vld[ax] = 1'b0;
                if (st_reg.snap_vld[ax]) begin
                    st_next.tx = st_reg.snap[ax];
                end else begin
                    st_next.tx = st_reg.rate[ax][31:16];
                end
            end
        end else if (word_evt) begin
            if (same_word(addr, ADDR_MISC_IO)) begin
                if (addr[0]) begin
                    st_next.misc[15:8] = wdata;
                end else begin
                    st_next.misc[7:0] = wdata;
                end
            end else if (addr == ADDR_GLOBAL_COMMAND) begin
                st_next.cmd_crc    = wdata[CMD_CRCTEST];
                st_next.cmd_self   = wdata[CMD_SELFTEST];
                st_next.cmd_update = wdata[CMD_UPDATE];
                st_next.cmd_reset  = wdata[CMD_RESET];
            end
        end
    end

    // *****************************************************************
    // State register
    // *****************************************************************
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            st_reg          <= '0;
            st_reg.s1       <= SYNC_RST;
            st_reg.s2       <= SYNC_RST;
            st_reg.s3       <= SYNC_RST;
            st_reg.filt     <= SYNC_RST;
            st_reg.cs_seen  <= 1'b1;
            st_reg.flags    <= FLAGS_RST;
            st_reg.misc     <= MISC_IO_RST;
            st_reg.pwr      <= PWR_RUN;
        end else begin
            st_reg <= st_next;
        end
    end

    // *****************************************************************
    // Outputs
    // *****************************************************************
    assign link.tx_word         = st_reg.tx;
    assign SYNC_MODE_O          = st_reg.misc[SYNC_MODE_LO+:2];
    assign CRC_TEST_START_O     = st_reg.cmd_crc;
    assign SELF_TEST_START_O    = st_reg.cmd_self;
    assign FLASH_UPDATE_START_O = st_reg.cmd_update;
    assign SOFT_RESET_O         = st_reg.cmd_reset;
    assign STANDBY_O            = (st_reg.pwr != PWR_RUN);
    assign REINIT_O             = st_reg.reinit;

endmodule

/* File: imd_diag_rate_properties.sv */
// Checker on the top ports of the flag and rate block
// Assumes one system clock domain with synchronous reset
`timescale 1ns/1ps
module imd_diag_rate_checker #(
    parameter int unsigned STANDBY_WAIT = 20
) (
    // Clock and reset
    input  wire logic       CLK_SYS_I,
    input  wire logic       RST_I,
    // Watched pins
    input  wire logic       SUPPLY_LOW_I,
    input  wire logic [1:0] SYNC_MODE_O,
    input  wire logic       CRC_TEST_START_O,
    input  wire logic       SELF_TEST_START_O,
    input  wire logic       FLASH_UPDATE_START_O,
    input  wire logic       SOFT_RESET_O,
    input  wire logic       STANDBY_O,
    input  wire logic       REINIT_O
);
    // *****
    // Run-up counter
    // *****
    int unsigned run_reg;
    int unsigned run_next;
    always_comb run_next = (!STANDBY_O || SUPPLY_LOW_I) ? 0 : run_reg + 1;
    always_ff @(posedge CLK_SYS_I) run_reg <= RST_I ? 0 : run_next;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    standby_entry_a:
        assert property (SUPPLY_LOW_I [*6] |-> STANDBY_O)
        else $error("standby missing after low supply");
    standby_hold_a:
        assert property (STANDBY_O && SUPPLY_LOW_I |=> STANDBY_O [*8])
        else $error("standby left too early");
    standby_wait_a:
        assert property ($fell(STANDBY_O) |-> run_reg >= STANDBY_WAIT)
        else $error("standby wait too short");
    reinit_exit_a:
        assert property ($fell(STANDBY_O) |-> ##[0:1] REINIT_O)
        else $error("no reinit on leaving standby");
    reinit_pulse_a:
        assert property (REINIT_O |=> !REINIT_O)
        else $error("reinit longer than one cycle");
    crc_pulse_a:
        assert property (CRC_TEST_START_O |=> !CRC_TEST_START_O)
        else $error("crc start longer than one cycle");
    selftest_pulse_a:
        assert property (SELF_TEST_START_O |=> !SELF_TEST_START_O)
        else $error("self test start too long");
    update_pulse_a:
        assert property (FLASH_UPDATE_START_O |=> !FLASH_UPDATE_START_O)
        else $error("update start too long");
    soft_reset_a:
        assert property (SOFT_RESET_O |=> !SOFT_RESET_O)
        else $error("soft reset too long");
    sync_init_a:
        assert property ($fell(RST_I) |-> SYNC_MODE_O == 2'h0)
        else $error("sync mode not cleared by reset");
endmodule
bind imd_diag_rate imd_diag_rate_checker #(.STANDBY_WAIT(STANDBY_WAIT)) chk_i (
    .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .SUPPLY_LOW_I(SUPPLY_LOW_I),
    .SYNC_MODE_O(SYNC_MODE_O), .CRC_TEST_START_O(CRC_TEST_START_O),
    .SELF_TEST_START_O(SELF_TEST_START_O),
    .FLASH_UPDATE_START_O(FLASH_UPDATE_START_O),
    .SOFT_RESET_O(SOFT_RESET_O), .STANDBY_O(STANDBY_O), .REINIT_O(REINIT_O));

/* File: imd_spi_host.sv */
// Host model clocking 16-bit words over the serial link
// Assumes mode 3 framing; caller waits until reset is over
`timescale 1ns/1ps
module imd_spi_host (
    // Link pins
    output logic        sclk_o,
    output logic        cs_n_o,
    output logic        din_o,
    input  wire logic   dout_i,
    // Returned word
    output logic [15:0] rx_o,
    output logic        rx_v_o
);
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
        rx_o   = 16'h0000;
        rx_v_o = 1'b0;
    end
    // One frame of n clocks, then the idle gap
    task automatic xfer(input logic [15:0] w, input int n);
        logic [15:0] r;
        r = 16'h0000;
        cs_n_o = 1'b0;
        din_o = w[15];
        for (int k = 1; k <= n; k++) begin
            #32 sclk_o = 1'b0;
            #32 r = {r[14:0], dout_i};
            sclk_o = 1'b1;
            #1 din_o = w[(31 - k) % 16];
        end
        #31 cs_n_o = 1'b1;
        din_o = ~din_o;
        rx_o = r;
        rx_v_o = 1'b1;
        #1 rx_v_o = 1'b0;
        #512;
    endtask
endmodule

/* File: imd_tb.sv */
// Self-checking bench for the flag and rate block
// Assumes the host model drives the clock, select and data-in pins of the serial link
`timescale 1ns/1ps
module testbench;
    import imd_pkg::*;
    // *****
    // Signals
    // *****
    localparam logic [8:0]  pat_tab [6] = '{9'h001, 9'h002, 9'h006,
                                            9'h018, 9'h020, 9'h080};
    localparam logic [15:0] exp_tab [6] = '{16'h0000, 16'h0000, 16'h0040,
                                            16'h0020, 16'h0004, 16'h0002};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [8:0]  cv = 9'h000;
    logic        rv = 1'b0;
    imd_rate_t   rt [3] = '{default: 32'h0};
    logic        sclk, cs_n, din, dout, oe_n, rx_v, stby, reinit;
    logic [1:0]  smode;
    logic [3:0]  st;
    logic [15:0] rx;
    logic [31:0] q [$];
    int          err_total = 0;
    int          n_checks = 0;
    int          pc = 0;
    imd_diag_rate #(.STANDBY_WAIT(20)) dut (
        .CLK_SYS_I(clk), .RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n),
        .DIN_I(din), .DOUT_O(dout), .DOUT_OE_N_O(oe_n),
        .RATE_X_I(rt[0]), .RATE_Y_I(rt[1]), .RATE_Z_I(rt[2]),
        .RATE_VALID_I(rv), .CLK_UNLOCK_I(cv[0]),
        .CRC_TEST_DONE_I(cv[1]), .CRC_MISMATCH_I(cv[2]),
        .SELF_TEST_DONE_I(cv[3]), .SENSOR_FAIL_I(cv[4]),
        .FLASH_UPDATE_DONE_I(cv[5]), .FLASH_UPDATE_OK_I(cv[6]),
        .OVERRUN_I(cv[7]), .SUPPLY_LOW_I(cv[8]), .SYNC_MODE_O(smode),
        .CRC_TEST_START_O(st[0]), .SELF_TEST_START_O(st[1]),
        .FLASH_UPDATE_START_O(st[2]), .SOFT_RESET_O(st[3]),
        .STANDBY_O(stby), .REINIT_O(reinit));
    imd_spi_host host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
        .dout_i(dout), .rx_o(rx), .rx_v_o(rx_v));
    always #25 clk = ~clk;
    always @(posedge clk) pc <= pc + st[0] + st[1] + st[2] + st[3];
    // *****
    // Tasks
    // *****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic xf(input logic [15:0] w, input logic [31:0] e,
                      input int n = 16);
        q.push_back(e);
        host.xfer(w, n);
        cyc(1);
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        xf({1'b0, a, 8'h00}, {16'hFFFF, e});
    endtask
    task automatic strobe;
        rv = 1'b1;
        cyc(1);
        rv = 1'b0;
    endtask
    function automatic logic [31:0] clamp(input logic [31:0] x);
        if ($signed(x) > $signed(RATE_POS_FS)) return RATE_POS_FS;
        if ($signed(x) < $signed(RATE_NEG_FS)) return RATE_NEG_FS;
        return x;
    endfunction
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge rx_v) begin
        logic [31:0] e;
        e = q.pop_front();
        if (e[31:16] != 16'h0000) chk(rx, e[15:0]);
    end
    initial begin
        #500000;
        err_total++;
        final_report();
    end
    initial begin
        logic [31:0] v;
        q.push_back(32'h0);
        void'($urandom(74));
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        cyc(8);
        chk({15'h0000, oe_n}, 16'h0001);
        rd(ADDR_DIAG, 16'h0000);
        rd(7'h20, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            cv = pat_tab[i];
            cyc(1);
            cv = 9'h000;
            rd(ADDR_DIAG, exp_tab[i]);
        end
        xf({1'b1, ADDR_MISC_IO, 8'hC9}, 32'h0);
        chk({14'h0, smode}, 16'h0002);
        xf(16'h0000, 32'h0, 15);
        rd(ADDR_MISC_IO, 16'h00C9);
        cv[0] = 1'b1;
        cyc(1);
        cv[0] = 1'b0;
        rd(ADDR_DIAG, 16'h0088);
        cv[7] = 1'b1;
        cyc(2);
        rd(ADDR_DIAG, 16'h0002);
        rd(ADDR_DIAG, 16'h0002);
        cv[7] = 1'b0;
        rd(ADDR_DIAG, 16'h0002);
        rd(ADDR_DIAG, 16'h0000);
        cv[8] = 1'b1;
        cyc(10);
        cv[8] = 1'b0;
        cyc(40);
        rd(ADDR_DIAG, 16'h0010);
        rd(ADDR_DIAG, 16'h0000);
        xf({1'b1, ADDR_GLOBAL_COMMAND, 8'h9C}, 32'h0);
        cyc(12);
        chk(16'(pc), 16'h0004);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 32'h7FFFFFFF : (i == 1) ? 32'h80000000 : $urandom;
            rt[i % 3] = v;
            strobe();
            v = clamp(v);
            rd(ADDR_X_FRAC + 7'(4 * (i % 3)), v[15:0]);
            rd(ADDR_X_INT + 7'(4 * (i % 3)), v[31:16]);
        end
        rt[0] = 32'h12345678;
        strobe();
        rd(ADDR_X_FRAC, 16'h5678);
        rt[0] = 32'h0000ABCD;
        strobe();
        rd(ADDR_X_INT, 16'h1234);
        rd(ADDR_X_INT, 16'h0000);
        xf(16'h0000, 32'h0);
        final_report();
    end
endmodule
